// *** dual_prescaled_counter_timer.v ***
`timescale 1ns/10ps
`include "timer_defines.vh"
// Contract
// R1: Load bit copies initial values, then self-clears
// R2: Load while running restarts from new value
// R3: Counter idle while enable bit is zero
// R4: First decrement four clocks after enable
// R5: Load and enable together in one write
// R6: Prescaler reloads at its end, never zero
// R7: Prescaler carry decrements counter next tick
// R8: Both ends reached raise counter request
// R9: Single-pass holds 00h, continuous reloads
// R10: Divider bit 0 selects continuous mode
// R11: Clearing enable freezes, setting resumes
// R12: Counter read returns live count
// R13: Prescaler registers are write-only
// R14: New initial values act at next load
// R15: Timer clock is internal clock over four
// R16: Divider bits 7..2 are plain binary
// R17: Initial 01h one count, 00h 256
// R18: Line six must be configured as output
// R19: Mode bits 7..6 select output source
// R20: Load of selected counter forces output high
// R21: Selected end-of-count toggles output flip-flop
// R22: Port writes ignored on timer output line
// R23: Prescaler reads return FFh
// R24: Reset disables counters, single-pass, external source; no external source is built, both counters run on the timer clock
module dual_prescaled_counter_timer #(
   parameter PRESCALE_WIDTH = 6,
   parameter COUNT_WIDTH = 8
) (
   input wire sys_clk_in,
   input wire reset_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   output reg [7:0] reg_rdata_out,
   output reg timer_zero_request_out,
   output reg timer_one_request_out,
   output wire port3_line6_out,
   output wire port3_line6_oe_out
);
   // ************************************************************
   // Registers
   // ************************************************************
   reg [7:0] timer_mode_ctrl;
   reg [7:0] next_mode;
   reg [7:0] timer0_divider_cfg;
   reg [7:0] timer1_divider_cfg;
   reg [COUNT_WIDTH-1:0] counter_zero_init;
   reg [COUNT_WIDTH-1:0] counter_one_init;
   reg [7:0] port3_data_reg;
   reg [7:0] port3_mode_reg;
   reg [1:0] quarter_div;
   reg [1:0] next_quarter_div;
   reg toggle_out;
   reg next_toggle;
   reg clock_phase;
   wire timer_tick;
   wire [COUNT_WIDTH-1:0] counter_zero;
   wire [COUNT_WIDTH-1:0] counter_one;
   wire end_zero;
   wire end_one;
   wire load_zero;
   wire load_one;
   wire force_high;
   wire toggle_event;
   wire [1:0] out_sel;
   wire timer_out_active;
   wire pin_level;
   wire [7:0] port_readback;
   wire [7:0] next_rdata;
   wire write_mode;
   assign write_mode = write_hit(reg_addr_in, `ADDR_TIMER_MODE_CTRL, reg_write_in);
   assign out_sel = timer_mode_ctrl[`MODE_OUT_HI_BIT:`MODE_OUT_LO_BIT];
   assign load_zero = timer_mode_ctrl[`MODE_LOAD0_BIT];
   assign load_one = timer_mode_ctrl[`MODE_LOAD1_BIT];
   // ************************************************************
   // Decoding helpers
   // ************************************************************
   // Address match for a register write in this clock
   function write_hit;
      input [7:0] addr;
      input [7:0] target;
      input strobe;
      begin
         write_hit = strobe && (addr == target);
      end
   endfunction
   // One decoder picks the driving counter, so load force and toggle never disagree
   function selected_event;
      input [1:0] sel;
      input event_zero;
      input event_one;
      begin
         case (sel)
            `OUT_SEL_ZERO: selected_event = event_zero;
            `OUT_SEL_ONE: selected_event = event_one;
            default: selected_event = 1'b0;
         endcase
      end
   endfunction
   // Readback mux; write-only prescalers answer with a constant
   function [7:0] read_value;
      input [7:0] addr;
      input [7:0] mode_value;
      input [7:0] zero_value;
      input [7:0] one_value;
      input [7:0] data_value;
      input [7:0] port_mode_value;
      begin
         case (addr)
            `ADDR_TIMER_MODE_CTRL: read_value = mode_value;
            `ADDR_COUNTER_ZERO: read_value = zero_value; // [R12]
            `ADDR_COUNTER_ONE: read_value = one_value; // [R12]
            `ADDR_TIMER0_DIVIDER_CFG: read_value = `PRESCALER_READ_VALUE; // [R13] [R23]
            `ADDR_TIMER1_DIVIDER_CFG: read_value = `PRESCALER_READ_VALUE; // [R13] [R23]
            `ADDR_PORT3_DATA_REG: read_value = data_value; // [R22]
            `ADDR_PORT3_MODE_REG: read_value = port_mode_value;
            default: read_value = 8'h00;
         endcase
      end
   endfunction
   // ************************************************************
   // Timer clock divider
   // ************************************************************
   // Any mode write restarts the phase, so the first decrement lands four clocks later
   always @* begin
      next_quarter_div = quarter_div + 2'h1; // [R15]
      if (write_mode) begin
         next_quarter_div = 2'h0; // [R4]
      end
   end
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         quarter_div <= 2'h0;
      end else begin
         quarter_div <= next_quarter_div;
      end
   end
   assign timer_tick = (quarter_div == 2'h3);
   // ************************************************************
   // Timer mode register
   // ************************************************************
   // Load bits live for one clock only; a write in that clock wins over the clear
   always @* begin
      next_mode = timer_mode_ctrl;
      next_mode[`MODE_LOAD0_BIT] = 1'b0; // [R1]
      next_mode[`MODE_LOAD1_BIT] = 1'b0; // [R1]
      if (write_mode) begin
         next_mode = reg_wdata_in; // [R5] [R3] [R11]
      end
   end
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         timer_mode_ctrl <= `TIMER_MODE_RESET; // [R24]
      end else begin
         timer_mode_ctrl <= next_mode;
      end
   end
   // ************************************************************
   // Divider and initial value registers
   // ************************************************************
   // Counter values wait here until the next load or reload; divider values are used live
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         timer0_divider_cfg <= `DIVIDER_CFG_RESET; // [R24]
         timer1_divider_cfg <= `DIVIDER_CFG_RESET; // [R24]
         counter_zero_init <= {COUNT_WIDTH{1'b0}};
         counter_one_init <= {COUNT_WIDTH{1'b0}};
      end else if (reg_write_in) begin
         case (reg_addr_in)
            `ADDR_TIMER0_DIVIDER_CFG: begin
               timer0_divider_cfg <= reg_wdata_in; // [R14]
            end
            `ADDR_TIMER1_DIVIDER_CFG: begin
               timer1_divider_cfg <= reg_wdata_in; // [R14]
            end
            `ADDR_COUNTER_ZERO: begin
               counter_zero_init <= reg_wdata_in[COUNT_WIDTH-1:0];
            end
            `ADDR_COUNTER_ONE: begin
               counter_one_init <= reg_wdata_in[COUNT_WIDTH-1:0];
            end
            default: begin
            end
         endcase
      end
   end
   // ************************************************************
   // Port three registers
   // ************************************************************
   // Modelled here so the pin and its readback stay in one place
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         port3_data_reg <= 8'h00;
         port3_mode_reg <= 8'h00;
      end else if (write_hit(reg_addr_in, `ADDR_PORT3_DATA_REG, reg_write_in)) begin
         port3_data_reg <= reg_wdata_in; // [R22]
      end else if (write_hit(reg_addr_in, `ADDR_PORT3_MODE_REG, reg_write_in)) begin
         port3_mode_reg <= reg_wdata_in; // [R18]
      end
   end
   // ************************************************************
   // Counter channels
   // ************************************************************
   timer_channel #(
      .PRESCALE_WIDTH(PRESCALE_WIDTH),
      .COUNT_WIDTH(COUNT_WIDTH)
   ) channel_zero (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tick_in(timer_tick),
      .load_in(timer_mode_ctrl[`MODE_LOAD0_BIT]),
      .enable_in(timer_mode_ctrl[`MODE_ENABLE0_BIT]),
      .continuous_in(timer0_divider_cfg[`DIV_CONT_BIT]), // [R10]
      .prescale_init_in(timer0_divider_cfg[7:2]), // [R16]
      .count_init_in(counter_zero_init),
      .count_out(counter_zero),
      .end_count_out(end_zero)
   );
   // External source modes are not built; counter one always runs on the timer clock
   timer_channel #(
      .PRESCALE_WIDTH(PRESCALE_WIDTH),
      .COUNT_WIDTH(COUNT_WIDTH)
   ) channel_one (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tick_in(timer_tick),
      .load_in(timer_mode_ctrl[`MODE_LOAD1_BIT]),
      .enable_in(timer_mode_ctrl[`MODE_ENABLE1_BIT]),
      .continuous_in(timer1_divider_cfg[`DIV_CONT_BIT]), // [R10]
      .prescale_init_in(timer1_divider_cfg[7:2]), // [R16]
      .count_init_in(counter_one_init),
      .count_out(counter_one),
      .end_count_out(end_one)
   );
   // ************************************************************
   // Interrupt requests
   // ************************************************************
   // Registered so each request is a clean one-clock pulse
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         timer_zero_request_out <= 1'b0;
         timer_one_request_out <= 1'b0;
      end else begin
         timer_zero_request_out <= end_zero; // [R8]
         timer_one_request_out <= end_one; // [R8]
      end
   end
   // ************************************************************
   // Internal clock output phase
   // ************************************************************
   // A pin cannot follow sys_clk_in itself, so a half-rate square wave stands in
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         clock_phase <= 1'b0;
      end else begin
         clock_phase <= ~clock_phase;
      end
   end
   // ************************************************************
   // Timer output toggle
   // ************************************************************
   assign force_high = selected_event(out_sel, load_zero, load_one); // [R20]
   assign toggle_event = selected_event(out_sel, end_zero, end_one); // [R21]
   always @* begin
      next_toggle = toggle_out;
      if (force_high) begin
         next_toggle = 1'b1; // [R20]
      end else if (toggle_event) begin
         next_toggle = ~toggle_out; // [R21]
      end
   end
   // Comes out of reset high, matching the level a fresh load gives
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         toggle_out <= 1'b1;
      end else begin
         toggle_out <= next_toggle;
      end
   end
   // ************************************************************
   // Pin drive
   // ************************************************************
   // Direction comes only from the port mode bit; software must clear it
   assign timer_out_active = (out_sel != `OUT_SEL_OFF);
   assign pin_level = (out_sel == `OUT_SEL_CLOCK) ? clock_phase :
                      timer_out_active ? toggle_out : port3_data_reg[`PORT3_LINE6_BIT]; // [R19] [R22]
   assign port3_line6_out = pin_level;
   assign port3_line6_oe_out = ~port3_mode_reg[`PORT3_MODE_OUT_BIT]; // [R18]
   // ************************************************************
   // Register reads
   // ************************************************************
   // Counts pass straight through, so a read never stalls the chain
   assign port_readback = {port3_data_reg[7], pin_level, port3_data_reg[5:0]}; // [R22]
   assign next_rdata = read_value(reg_addr_in, timer_mode_ctrl, counter_zero, counter_one, port_readback,
      port3_mode_reg);
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_read_in) begin
         reg_rdata_out <= next_rdata; // [R12]
      end
   end
endmodule // dual_prescaled_counter_timer

// *** tb.sv ***
`timescale 1ns/10ps
// ************************************************************
// Register level bench
// ************************************************************
module tb;
   reg sys_clk_in = 1'b0;
   reg reset_in = 1'b1;
   reg [7:0] reg_addr_in = 8'h00;
   reg [7:0] reg_wdata_in = 8'h00;
   reg reg_write_in = 1'b0;
   reg reg_read_in = 1'b0;
   wire [7:0] reg_rdata_out;
   wire req0, req1, pin, oe;
   integer fail_count = 0;
   integer comparisons = 0;
   integer i, n, p, v;
   reg [7:0] a, b;
   reg [5:0] pt [0:3] = '{6'h01, 6'h03, 6'h3F, 6'h02};
   reg [7:0] vt [0:3] = '{8'h01, 8'h02, 8'h01, 8'h00};
   dual_prescaled_counter_timer uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
      .reg_rdata_out(reg_rdata_out), .timer_zero_request_out(req0), .timer_one_request_out(req1),
      .port3_line6_out(pin), .port3_line6_oe_out(oe));
   initial begin
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   task complete_run;
      begin
         if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask
   task chk(input string s, input [7:0] e, input [7:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
         end
      end
   endtask
   task wr(input [7:0] ad, input [7:0] d);
      begin
         @(negedge sys_clk_in);
         reg_addr_in = ad;
         reg_wdata_in = d;
         reg_write_in = 1'b1;
         @(negedge sys_clk_in);
         reg_write_in = 1'b0;
      end
   endtask
   task rd(input [7:0] ad, output [7:0] d);
      begin
         @(negedge sys_clk_in);
         reg_addr_in = ad;
         reg_read_in = 1'b1;
         @(negedge sys_clk_in);
         reg_read_in = 1'b0;
         d = reg_rdata_out;
      end
   endtask
   // Waits past one request pulse so the next wait cannot see it again
   task wt(input w, input integer bound);
      begin
         n = 0;
         while ((w ? req1 : req0) !== 1'b1) begin
            @(negedge sys_clk_in);
            n = n + 1;
            if (n > bound) begin
               chk("request", 8'h01, 8'h00);
               complete_run;
            end
         end
         @(negedge sys_clk_in);
      end
   endtask
   initial begin
      repeat (3) @(negedge sys_clk_in);
      reset_in = 1'b0;
      rd(8'hF1, a);
      chk("mode reset", 8'h00, a);
      chk("oe reset", 8'h01, oe);
      wr(8'hF5, 8'h04);
      rd(8'hF5, a);
      chk("div0 read", 8'hFF, a);
      rd(8'hF3, a);
      chk("div1 read", 8'hFF, a);
      wr(8'hF4, 8'h05);
      wr(8'hF1, 8'h01);
      repeat (40) @(negedge sys_clk_in);
      rd(8'hF4, a);
      chk("idle count", 8'h05, a);
      rd(8'hF1, a);
      chk("load clear", 8'h00, a);
      for (i = 0; i < 4; i = i + 1) begin
         p = pt[i];
         v = (vt[i] == 8'h00) ? 256 : vt[i];
         wr(8'hF5, {pt[i], 2'h0});
         wr(8'hF4, vt[i]);
         wr(8'hF1, 8'h03);
         wt(0, 4 * p * v + 20);
         chk("interval", 8'h01, n >= 4 * p * v - 1 && n <= 4 * p * v + 3);
         rd(8'hF4, a);
         chk("rest value", 8'h00, a);
         rd(8'hF1, a);
         chk("load bit", 8'h02, a);
         n = 0;
         repeat (4 * p * v + 8) begin
            @(negedge sys_clk_in);
            if (req0 === 1'b1) n = n + 1;
         end
         chk("rest quiet", 8'h00, n);
      end
      wr(8'hF5, 8'h09);
      wr(8'hF4, 8'h03);
      wr(8'hF1, 8'h43);
      wt(0, 60);
      chk("toggle low", 8'h00, pin);
      wr(8'hF4, 8'h01);
      wt(0, 60);
      chk("period", 8'h01, n >= 21 && n <= 25);
      chk("toggle high", 8'h01, pin);
      wt(0, 60);
      chk("new period", 8'h01, n >= 7 && n <= 11);
      wr(8'hF3, 8'h07);
      wr(8'hF2, 8'hC8);
      wr(8'hF1, 8'h0C);
      repeat (40) @(negedge sys_clk_in);
      wr(8'hF1, 8'h00);
      rd(8'hF2, a);
      repeat (40) @(negedge sys_clk_in);
      rd(8'hF2, b);
      chk("frozen", a, b);
      chk("live count", 8'h01, a < 8'hC8 && a > 8'hB8);
      wr(8'hF2, 8'h05);
      wr(8'hF1, 8'h08);
      repeat (40) @(negedge sys_clk_in);
      rd(8'hF2, b);
      chk("resumed", 8'h01, b < a && b > a - 8'h10);
      wr(8'hF1, 8'h0C);
      wt(1, 60);
      chk("retrigger", 8'h01, n >= 19 && n <= 23);
      wr(8'hF1, 8'hC0);
      a[0] = pin;
      @(negedge sys_clk_in);
      chk("clock out", !a[0], pin);
      wr(8'hF1, 8'h00);
      wr(8'hF6, 8'h40);
      chk("data out", 8'h01, pin);
      wr(8'hF1, 8'h80);
      a[0] = pin;
      wr(8'hF6, {1'b0, !a[0], 6'h00});
      chk("port held", a[0], pin);
      rd(8'hF6, b);
      chk("port read", pin, b[6]);
      wr(8'hF7, 8'h20);
      chk("oe off", 8'h00, oe);
      rd(8'h10, a);
      chk("unmapped", 8'h00, a);
      complete_run;
   end
endmodule // tb

// *** timer_channel.v ***
`timescale 1ns/10ps
`include "timer_defines.vh"
module timer_channel #(
   parameter PRESCALE_WIDTH = 6,
   parameter COUNT_WIDTH = 8
) (
   input wire sys_clk_in,
   input wire reset_in,
   input wire tick_in,
   input wire load_in,
   input wire enable_in,
   input wire continuous_in,
   input wire [PRESCALE_WIDTH-1:0] prescale_init_in,
   input wire [COUNT_WIDTH-1:0] count_init_in,
   output reg [COUNT_WIDTH-1:0] count_out,
   output reg end_count_out
);
   reg [PRESCALE_WIDTH-1:0] prescale;
   reg running;
   reg reload_pending;
   wire prescale_end;
   wire count_end;
   assign prescale_end = (prescale == {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1}) || (prescale == {PRESCALE_WIDTH{1'b0}});
   // Initial 00h counts as 256, so end is reached only when stepping from 01h
   assign count_end = (count_out == {{(COUNT_WIDTH-1){1'b0}}, 1'b1});
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         prescale <= {PRESCALE_WIDTH{1'b0}};
         count_out <= {COUNT_WIDTH{1'b0}};
         running <= 1'b0;
         reload_pending <= 1'b0;
         end_count_out <= 1'b0;
      end else begin
         end_count_out <= 1'b0;
         if (load_in) begin
            // Retrigger: counting goes on from the fresh value [R1] [R2] [R14]
            prescale <= prescale_init_in;
            count_out <= count_init_in;
            running <= 1'b1;
            reload_pending <= 1'b0;
         end else if (enable_in && running && tick_in) begin // [R3] [R4] [R11] [R15]
            if (reload_pending) begin
               // Continuous reload lands on the timer clock after end [R14] [R9]
               prescale <= prescale_init_in;
               count_out <= count_init_in;
               reload_pending <= 1'b0;
            end else if (prescale_end) begin
               prescale <= prescale_init_in; // [R6] [R16]
               count_out <= count_out - {{(COUNT_WIDTH-1){1'b0}}, 1'b1}; // [R7] [R17]
               if (count_end) begin
                  end_count_out <= 1'b1; // [R8]
                  if (continuous_in) begin // [R10]
                     reload_pending <= 1'b1;
                  end else begin
                     running <= 1'b0; // Rest at 00h [R9]
                  end
               end
            end else begin
               prescale <= prescale - {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // timer_channel

// *** timer_defines.vh ***
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// ************************************************************
// Register offsets
// ************************************************************
`define ADDR_TIMER_MODE_CTRL 8'hF1
`define ADDR_COUNTER_ONE 8'hF2
`define ADDR_TIMER1_DIVIDER_CFG 8'hF3
`define ADDR_COUNTER_ZERO 8'hF4
`define ADDR_TIMER0_DIVIDER_CFG 8'hF5
`define ADDR_PORT3_DATA_REG 8'hF6
`define ADDR_PORT3_MODE_REG 8'hF7
// ************************************************************
// Field positions
// ************************************************************
`define MODE_LOAD0_BIT 0
`define MODE_ENABLE0_BIT 1
`define MODE_LOAD1_BIT 2
`define MODE_ENABLE1_BIT 3
`define MODE_OUT_LO_BIT 6
`define MODE_OUT_HI_BIT 7
`define DIV_CONT_BIT 0
`define DIV_CLKSRC_BIT 1
`define PORT3_MODE_OUT_BIT 5
`define PORT3_LINE6_BIT 6
// ************************************************************
// Encodings and reset values
// ************************************************************
`define OUT_SEL_OFF 2'h0
`define OUT_SEL_ZERO 2'h1
`define OUT_SEL_ONE 2'h2
`define OUT_SEL_CLOCK 2'h3
`define PRESCALER_READ_VALUE 8'hFF
`define TIMER_MODE_RESET 8'h00
`define DIVIDER_CFG_RESET 8'h00
`define TIMER_CLOCK_DIVIDE 4
`endif

// *** timer_sva.sv ***
`timescale 1ns/10ps
// ************************************************************
// Port checker
// ************************************************************
module timer_sva (
   input wire sys_clk_in,
   input wire reset_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   input wire [7:0] reg_rdata_out,
   input wire timer_zero_request_out,
   input wire timer_one_request_out,
   input wire port3_line6_out,
   input wire port3_line6_oe_out
);
   // Shadow of output select and port bit, since the checker cannot see inside
   reg [1:0] sel;
   reg d6;
   wire wr_mode = reg_write_in && reg_addr_in == 8'hF1;
   always @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         sel <= 2'h0;
         d6 <= 1'b0;
      end else begin
         if (wr_mode) sel <= reg_wdata_in[7:6];
         if (reg_write_in && reg_addr_in == 8'hF6) d6 <= reg_wdata_in[6];
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   a_div_read_ff: assert property (reg_read_in && (reg_addr_in == 8'hF3 || reg_addr_in == 8'hF5)
      |=> reg_rdata_out == 8'hFF) else $error("divider read not FFh");
   a_oe_from_mode: assert property (reg_write_in && reg_addr_in == 8'hF7
      |=> port3_line6_oe_out == !$past(reg_wdata_in[5])) else $error("line six enable wrong");
   a_zero_req_pulse: assert property ($rose(timer_zero_request_out) |=> !timer_zero_request_out)
      else $error("zero request too long");
   a_one_req_pulse: assert property ($rose(timer_one_request_out) |=> !timer_one_request_out)
      else $error("one request too long");
   // A load restarts the chain, so no end can follow within one tick
   a_load_quiet: assert property (wr_mode && reg_wdata_in[0] |-> ##3 !timer_zero_request_out [*2])
      else $error("request right after load");
   a_load_out_high: assert property (wr_mode && reg_wdata_in[7:6] == 2'h1 && reg_wdata_in[0]
      |-> ##3 port3_line6_out) else $error("load did not force output high");
   a_clock_out: assert property (sel == 2'h3 [*3] |-> port3_line6_out != $past(port3_line6_out))
      else $error("clock output not toggling");
   a_data_out: assert property (sel == 2'h0 && $past(sel) == 2'h0 |-> port3_line6_out == d6)
      else $error("data output wrong");
   a_unmapped_zero: assert property (reg_read_in && reg_addr_in < 8'hF1 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
endmodule // timer_sva
bind dual_prescaled_counter_timer timer_sva chk (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
   .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .timer_zero_request_out(timer_zero_request_out),
   .timer_one_request_out(timer_one_request_out), .port3_line6_out(port3_line6_out),
   .port3_line6_oe_out(port3_line6_oe_out));
